// ### src/fsk_modem_pkg.sv
// Shared constants for the 1200 bit/s frequency-shift-keying modem
package fsk_modem_pkg;
    // Core clock and the master tick that both ends agree on
    localparam int CORE_CLK_HZ = 200_000_000;
    localparam int MASTER_HZ = 460_800;
    localparam int MASTER_DIV = CORE_CLK_HZ / MASTER_HZ;
    localparam int BIT_RATE = 1200;

    // User clock: sixteen times the bit rate, toggled every half period
    localparam int USER_MULT = 16;
    localparam int USER_HALF_TICKS = MASTER_HZ / (USER_MULT * BIT_RATE * 2);

    // Tone synthesis: prescale by 5.5 or 3, then a common divide by 70
    localparam int MARK_PRE_X2 = 11;
    localparam int SPACE_PRE_X2 = 6;
    localparam int TONE_DIV = 70;
    localparam int TONE_HALF = TONE_DIV / 2;

    // Carrier band limits and slicer point, in hertz
    localparam int CD_MIN_HZ = 1000;
    localparam int CD_MAX_HZ = 2575;
    localparam int SLICE_HZ = 1700;

    // Half-period limits in master ticks; inclusive band edges
    localparam int HALF_MIN_TICKS = MASTER_HZ / (2 * CD_MAX_HZ);
    localparam int HALF_MAX_TICKS =
        (MASTER_HZ + 2 * CD_MIN_HZ - 1) / (2 * CD_MIN_HZ);
    localparam int HALF_SLICE_TICKS = MASTER_HZ / (2 * SLICE_HZ);

    // Loss of carrier: least hold time, rounded up to whole ticks
    localparam int LOSS_US = 1000;
    localparam int LOSS_TICKS = (LOSS_US * MASTER_HZ + 999_999) / 1_000_000;

    // Counter widths
    localparam int IVL_W = 9;
    localparam int HOLD_W = 10;
    localparam int PRE_W = 4;
    localparam int TONE_W = 7;
    localparam int USER_W = 4;
    localparam int BITCNT_W = 5;
    localparam int MDIV_W = 16;

    typedef enum logic [0:0] {
        CD_SEARCH = 1'b0,
        CD_LOCKED = 1'b1
    } carrier_state_t;
endpackage : fsk_modem_pkg

// ### src/fsk_link_if.sv
// Pin-level link between the modem core and its host
`timescale 1ns/100ps
interface fsk_link_if;
    logic master_clock_in;
    logic tx_request_n;
    logic tx_data_in;
    logic tx_carrier_out;
    logic tx_carrier_oe;
    logic rx_carrier_in;
    logic rx_data_out;
    logic carrier_present_n;
    logic user_clock_out;
    logic factory_test_a;
    logic factory_test_b;

    modport device (
        input master_clock_in,
        input tx_request_n,
        input tx_data_in,
        input rx_carrier_in,
        input factory_test_a,
        input factory_test_b,
        output tx_carrier_out,
        output tx_carrier_oe,
        output rx_data_out,
        output carrier_present_n,
        output user_clock_out
    );

    modport host (
        output master_clock_in,
        output tx_request_n,
        output tx_data_in,
        output rx_carrier_in,
        output factory_test_a,
        output factory_test_b,
        input tx_carrier_out,
        input tx_carrier_oe,
        input rx_data_out,
        input carrier_present_n,
        input user_clock_out
    );
endinterface : fsk_link_if

// ### src/fsk_modem_core.sv
// Modem core: tone synthesis, demodulator and carrier detector
//
// Functional notes
// - Host supplies 460.8 kHz master clock
// - User clock out at sixteen times bitrate
// - Mode line low transmits, high receives
// - Transmit output undriven while receiving
// - Mark 1200 Hz, space 2200 Hz out
// - Received 1200 Hz gives 1, 2200 gives 0
// - Demodulate only in receive mode
// - Frequency switch keeps phase continuous
// - Host holds NRZ level whole bit
// - Up to 1200 bit/s, one direction
// - Carrier detect low for 1000-2575 Hz
// - Detect by timing edge intervals
// - Detect asserts within one bit time
// - Release after 1 ms without carrier
// - Release within 1.68 ms of loss
// - Out-of-band intervals drop carrier detect
// - Unused modulator stops being clocked; detector always runs
// - Factory test inputs tied low
// - Tones: divide 5.5 or 3, then 70
// - Detector sees own transmitted carrier
`timescale 1ns/100ps
module fsk_modem_core (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    fsk_link_if.device link
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [1:0] mode_sync_reg;
    logic [1:0] txd_sync_reg;
    logic [1:0] rxc_sync_reg;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mode_sync_reg <= 2'h3;
            txd_sync_reg <= 2'h3;
            rxc_sync_reg <= 2'h0;
        end else begin
            mode_sync_reg <= {mode_sync_reg[0], link.tx_request_n};
            txd_sync_reg <= {txd_sync_reg[0], link.tx_data_in};
            rxc_sync_reg <= {rxc_sync_reg[0], link.rx_carrier_in};
        end
    end

    wire rx_mode = mode_sync_reg[1];
    wire tx_mode = !mode_sync_reg[1];
    wire tx_bit = txd_sync_reg[1];
    wire rx_line = rxc_sync_reg[1];
    // Test inputs are expected low; either one high freezes the demodulator output
    wire unused_test = link.factory_test_a | link.factory_test_b;

    // Every timing below advances only on the master tick
    wire tick = link.master_clock_in;
    wire tx_tick = tick & tx_mode;

    ////////////////////////////////////////////////////////////////////////
    // User clock

    logic [fsk_modem_pkg::USER_W-1:0] user_cnt_reg;
    logic user_clk_reg;

    wire user_wrap =
        user_cnt_reg == fsk_modem_pkg::USER_W'(fsk_modem_pkg::USER_HALF_TICKS - 1);
    wire [fsk_modem_pkg::USER_W-1:0] user_cnt_next =
        user_wrap ? '0 : user_cnt_reg + 1'b1;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            user_cnt_reg <= '0;
            user_clk_reg <= 1'b0;
        end else if (tick) begin
            user_cnt_reg <= user_cnt_next;
            if (user_wrap) begin
                user_clk_reg <= !user_clk_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Modulator: fractional prescaler feeding a shared divide by 70.
    // The divide-by-70 stage is never reset on a data change, so the
    // output waveform carries on from its current phase.

    logic [fsk_modem_pkg::PRE_W-1:0] pre_acc_reg;
    logic [fsk_modem_pkg::TONE_W-1:0] tone_cnt_reg;
    logic tone_reg;

    wire [fsk_modem_pkg::PRE_W-1:0] pre_limit = tx_bit ?
        fsk_modem_pkg::PRE_W'(fsk_modem_pkg::MARK_PRE_X2) :
        fsk_modem_pkg::PRE_W'(fsk_modem_pkg::SPACE_PRE_X2);
    wire [fsk_modem_pkg::PRE_W-1:0] pre_sum = pre_acc_reg + 4'h2;
    wire pre_fire = pre_sum >= pre_limit;
    wire [fsk_modem_pkg::PRE_W-1:0] pre_acc_next =
        pre_fire ? pre_sum - pre_limit : pre_sum;
    wire tone_wrap =
        tone_cnt_reg == fsk_modem_pkg::TONE_W'(fsk_modem_pkg::TONE_HALF - 1);
    wire [fsk_modem_pkg::TONE_W-1:0] tone_cnt_next =
        tone_wrap ? '0 : tone_cnt_reg + 1'b1;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pre_acc_reg <= '0;
            tone_cnt_reg <= '0;
            tone_reg <= 1'b0;
        end else if (tx_tick) begin
            pre_acc_reg <= pre_acc_next;
            if (pre_fire) begin
                tone_cnt_reg <= tone_cnt_next;
                if (tone_wrap) begin
                    tone_reg <= !tone_reg;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge interval timer; in transmit mode it listens to our own tone

    logic det_prev_reg;
    logic det_mode_reg;
    logic [fsk_modem_pkg::IVL_W-1:0] ivl_cnt_reg;

    wire det_in = rx_mode ? rx_line : tone_reg;
    // Source swap is no carrier edge; restart the timer as after idle
    wire det_swap = det_mode_reg != rx_mode;
    wire det_edge = det_in != det_prev_reg && !det_swap;
    wire ivl_sat = &ivl_cnt_reg;
    wire ivl_in_band =
        ivl_cnt_reg >= fsk_modem_pkg::IVL_W'(fsk_modem_pkg::HALF_MIN_TICKS) &&
        ivl_cnt_reg <= fsk_modem_pkg::IVL_W'(fsk_modem_pkg::HALF_MAX_TICKS);
    wire valid_edge = det_edge && ivl_in_band;
    wire slow_tone =
        ivl_cnt_reg > fsk_modem_pkg::IVL_W'(fsk_modem_pkg::HALF_SLICE_TICKS);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            det_prev_reg <= 1'b0;
            det_mode_reg <= 1'b1;
            ivl_cnt_reg <= '1;
        end else begin
            det_prev_reg <= det_in;
            det_mode_reg <= rx_mode;
            if (det_swap) begin
                ivl_cnt_reg <= '1;
            end else if (det_edge) begin
                ivl_cnt_reg <= '0;
            end else if (tick && !ivl_sat) begin
                ivl_cnt_reg <= ivl_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Carrier detector. The first edge only starts the timer; the first
    // in-band interval then locks, well inside one bit time. Any edge that
    // falls out of band simply fails to refresh the hold timer, so a bad
    // carrier is dropped by the same loss timeout as a missing one.

    fsk_modem_pkg::carrier_state_t cd_state_reg;
    logic [fsk_modem_pkg::HOLD_W-1:0] hold_cnt_reg;

    wire hold_done =
        hold_cnt_reg >= fsk_modem_pkg::HOLD_W'(fsk_modem_pkg::LOSS_TICKS);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cd_state_reg <= fsk_modem_pkg::CD_SEARCH;
            hold_cnt_reg <= '0;
        end else begin
            unique case (cd_state_reg)
                fsk_modem_pkg::CD_SEARCH: begin
                    hold_cnt_reg <= '0;
                    if (valid_edge) begin
                        cd_state_reg <= fsk_modem_pkg::CD_LOCKED;
                    end
                end
                fsk_modem_pkg::CD_LOCKED: begin
                    if (valid_edge) begin
                        hold_cnt_reg <= '0;
                    end else if (hold_done) begin
                        cd_state_reg <= fsk_modem_pkg::CD_SEARCH;
                    end else if (tick) begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Demodulator: slices each in-band half period as mark or space.
    // Output holds its last value while transmitting.

    logic rx_data_reg;
    logic cd_out_reg;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_data_reg <= 1'b1;
            cd_out_reg <= 1'b1;
        end else begin
            if (rx_mode && valid_edge && !unused_test) begin
                rx_data_reg <= slow_tone;
            end
            cd_out_reg <= cd_state_reg != fsk_modem_pkg::CD_LOCKED;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign link.user_clock_out = user_clk_reg;
    assign link.tx_carrier_out = tone_reg;
    assign link.tx_carrier_oe = tx_mode;
    assign link.rx_data_out = rx_data_reg;
    assign link.carrier_present_n = cd_out_reg;

endmodule : fsk_modem_core

// ### src/fsk_modem_host.sv
// Host end: master clock, mode line, NRZ bit pacing and line buffering
`timescale 1ns/100ps
module fsk_modem_host #(
    parameter int MASTER_DIV = fsk_modem_pkg::MASTER_DIV
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic tx_enable_i,
    input wire logic tx_bit_i,
    input wire logic tx_bit_valid_i,
    output logic tx_bit_ready_o,
    input wire logic line_rx_i,
    output logic line_tx_o,
    output logic line_tx_oe_o,
    output logic rx_bit_o,
    output logic carrier_o,
    fsk_link_if.host link
);

    ////////////////////////////////////////////////////////////////////////
    // Master clock as a one-cycle tick

    logic [fsk_modem_pkg::MDIV_W-1:0] mdiv_reg;
    wire mdiv_wrap = mdiv_reg == fsk_modem_pkg::MDIV_W'(MASTER_DIV - 1);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mdiv_reg <= '0;
        end else begin
            mdiv_reg <= mdiv_wrap ? '0 : mdiv_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit pacing: each accepted bit is held for sixteen user clocks

    logic user_prev_reg;
    logic [fsk_modem_pkg::BITCNT_W-1:0] bit_cnt_reg;
    logic txd_reg;
    logic mode_n_reg;
    logic line_rx_reg;
    logic rx_bit_reg;
    logic carrier_reg;

    wire user_rise = link.user_clock_out && !user_prev_reg;
    wire bit_idle = bit_cnt_reg == '0;
    wire accept = tx_bit_valid_i && tx_bit_ready_o;

    assign tx_bit_ready_o = bit_idle && tx_enable_i && !mode_n_reg;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            user_prev_reg <= 1'b0;
            bit_cnt_reg <= '0;
            txd_reg <= 1'b1;
            mode_n_reg <= 1'b1;
        end else begin
            user_prev_reg <= link.user_clock_out;
            // Mode may only change between bits
            if (bit_idle) begin
                mode_n_reg <= !tx_enable_i;
            end
            if (accept) begin
                txd_reg <= tx_bit_i;
                bit_cnt_reg <= fsk_modem_pkg::BITCNT_W'(fsk_modem_pkg::USER_MULT);
            end else if (user_rise && !bit_idle) begin
                bit_cnt_reg <= bit_cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            line_rx_reg <= 1'b0;
            rx_bit_reg <= 1'b1;
            carrier_reg <= 1'b0;
        end else begin
            line_rx_reg <= line_rx_i;
            rx_bit_reg <= link.rx_data_out;
            carrier_reg <= !link.carrier_present_n;
        end
    end

    assign link.master_clock_in = mdiv_wrap;
    assign link.tx_request_n = mode_n_reg;
    assign link.tx_data_in = txd_reg;
    assign link.rx_carrier_in = line_rx_reg;
    assign link.factory_test_a = 1'b0;
    assign link.factory_test_b = 1'b0;
    assign line_tx_o = link.tx_carrier_oe & link.tx_carrier_out;
    assign line_tx_oe_o = link.tx_carrier_oe;
    assign rx_bit_o = rx_bit_reg;
    assign carrier_o = carrier_reg;

endmodule : fsk_modem_host

// ### testbench/fsk_modem_assertions.sv
// Concurrent checks on the modem link between core and host
`timescale 1ns/100ps
module fsk_modem_assertions (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic master_clock_in,
    input wire logic tx_request_n,
    input wire logic rx_carrier_in,
    input wire logic tx_carrier_out,
    input wire logic tx_carrier_oe,
    input wire logic carrier_present_n,
    input wire logic user_clock_out
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////
    // Tick counters since the last change of each watched line
    logic uc_d;
    logic tn_d;
    logic rx_d;
    logic uc_arm;
    logic tn_arm;
    logic [4:0] uc_tk;
    logic [8:0] tn_tk;
    logic [9:0] ed_tk;
    wire tk = master_clock_in;
    wire uc_chg = user_clock_out ^ uc_d;
    wire tn_chg = tx_carrier_out ^ tn_d;
    // Own tone counts as an edge: the detector hears it too
    wire ed_chg = tn_chg | (rx_carrier_in ^ rx_d);

    always_ff @(posedge core_clk_i) begin
        uc_d <= user_clock_out;
        tn_d <= tx_carrier_out;
        rx_d <= rx_carrier_in;
        if (!rst_n_i) begin
            uc_arm <= 1'b0;
            tn_arm <= 1'b0;
            uc_tk <= 5'h00;
            tn_tk <= 9'h000;
            ed_tk <= 10'h000;
        end else begin
            uc_arm <= uc_arm | uc_chg;
            tn_arm <= tx_carrier_oe & (tn_arm | tn_chg);
            uc_tk <= uc_chg ? 5'(tk) : uc_tk + 5'(tk);
            tn_tk <= tn_chg ? 9'(tk) : tn_tk + 9'(tk);
            if (ed_chg) begin
                ed_tk <= 10'(tk);
            end else if (ed_tk != 10'h3FF) begin
                ed_tk <= ed_tk + 10'(tk);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_reset_idle: assert property (
        $rose(rst_n_i) |-> carrier_present_n && !user_clock_out
            && !tx_carrier_out)
        else $error("outputs not idle after reset");
    a_user_half: assert property (
        uc_chg && uc_arm |-> uc_tk == 5'h0C)
        else $error("user clock half period wrong");
    a_mode_rx: assert property (
        tx_request_n [*3] |=> !tx_carrier_oe)
        else $error("tone driven in receive mode");
    a_mode_tx: assert property (
        !tx_request_n [*3] |=> tx_carrier_oe)
        else $error("tone not driven in transmit mode");
    a_tone_frozen: assert property (
        !tx_carrier_oe [*3] |-> $stable(tx_carrier_out))
        else $error("tone runs in receive mode");
    a_tone_half: assert property (
        tn_chg && tn_arm && tx_carrier_oe |-> tn_tk inside {[9'h068:9'h0C2]})
        else $error("tone half period out of range");
    a_cd_edge: assert property (
        $fell(carrier_present_n) |-> ed_tk <= 10'h002)
        else $error("carrier detect without an edge");
    a_cd_release: assert property (
        !carrier_present_n |-> ed_tk <= 10'h307)
        else $error("carrier detect held too long");

    c_lock: cover property ($fell(carrier_present_n));
    c_unlock: cover property ($rose(carrier_present_n));
    c_tone: cover property (tn_chg && tn_arm && tx_carrier_oe);
endmodule : fsk_modem_assertions

// ### testbench/tb_fsk_modem_1200_bps.sv
// Self-checking bench: core and host joined across the modem link
`timescale 1ns/100ps
module tb_fsk_modem_1200_bps;
    // Short master tick period; all timing scales in ticks
    localparam int MD = 4;
    logic core_clk_i;
    logic rst_n_i = 1'b0;
    logic tx_enable_i = 1'b0;
    logic tx_bit_i = 1'b0;
    logic tx_bit_valid_i = 1'b0;
    logic line_rx_i = 1'b0;
    logic tx_bit_ready_o;
    logic line_tx_o;
    logic line_tx_oe_o;
    logic rx_bit_o;
    logic carrier_o;
    int n_fail = 0;
    int compares = 0;

    fsk_link_if link ();
    fsk_modem_core fsk_modem_core_i (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .link(link.device)
    );
    fsk_modem_host #(.MASTER_DIV(MD)) fsk_modem_host_i (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .tx_enable_i(tx_enable_i),
        .tx_bit_i(tx_bit_i),
        .tx_bit_valid_i(tx_bit_valid_i),
        .tx_bit_ready_o(tx_bit_ready_o),
        .line_rx_i(line_rx_i),
        .line_tx_o(line_tx_o),
        .line_tx_oe_o(line_tx_oe_o),
        .rx_bit_o(rx_bit_o),
        .carrier_o(carrier_o),
        .link(link.host)
    );
    fsk_modem_assertions fsk_modem_assertions_i (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .master_clock_in(link.master_clock_in),
        .tx_request_n(link.tx_request_n),
        .rx_carrier_in(link.rx_carrier_in),
        .tx_carrier_out(link.tx_carrier_out),
        .tx_carrier_oe(link.tx_carrier_oe),
        .carrier_present_n(link.carrier_present_n),
        .user_clock_out(link.user_clock_out)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : cyc

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic tone(input int half, input int n);
        repeat (n) begin
            line_rx_i = ~line_rx_i;
            cyc(half * MD);
        end
    endtask : tone

    function automatic logic pick(input bit s);
        return s ? line_tx_o : link.user_clock_out;
    endfunction : pick

    task automatic until_lvl(input bit s, input bit v, output int n);
        n = 0;
        while (pick(s) !== v && n < 4000) begin
            cyc(1);
            n++;
        end
        check("level reached", v, pick(s));
    endtask : until_lvl

    // Rise-to-rise period in cycles
    task automatic gap(input bit s, output int g);
        int a;
        int b;
        until_lvl(s, 1'b0, a);
        until_lvl(s, 1'b1, a);
        until_lvl(s, 1'b0, a);
        until_lvl(s, 1'b1, b);
        g = a + b;
    endtask : gap

    // Valid stays up so back-to-back bits never re-toggle it
    task automatic send_bit(input logic b, output int n);
        n = 0;
        tx_bit_i = b;
        tx_bit_valid_i = 1'b1;
        while (tx_bit_ready_o !== 1'b1 && n < 4000) begin
            cyc(1);
            n++;
        end
        check("bit ready", 1, tx_bit_ready_o);
        cyc(1);
    endtask : send_bit

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        int g;
        check("carrier", 0, carrier_o);
        check("tx oe", 0, line_tx_oe_o);
        gap(1'b0, g);
        check("user clock period", 24 * MD, g);
    endtask : t_reset

    task automatic t_rx;
        tone(192, 2);
        check("lock in bit time", 1, carrier_o);
        tone(192, 2);
        check("mark bit", 1, rx_bit_o);
        tone(105, 4);
        check("space bit", 0, rx_bit_o);
        tone(230, 2);
        check("low band edge", 1, carrier_o);
        check("mark after space", 1, rx_bit_o);
        tone(90, 4);
        check("high band edge", 1, carrier_o);
        check("space after mark", 0, rx_bit_o);
        cyc(360 * MD);
        check("held 1 ms", 1, carrier_o);
        cyc(325 * MD);
        check("dropped", 0, carrier_o);
        tone(192, 3);
        tone(60, 20);
        check("out of band", 0, carrier_o);
        check("line idle", 0, line_tx_o);
    endtask : t_rx

    task automatic t_tx;
        int g;
        int n;
        tx_enable_i = 1'b1;
        send_bit(1'b1, n);
        cyc(4);
        check("tx oe", 1, line_tx_oe_o);
        gap(1'b1, g);
        check("mark period", 385 * MD, g);
        send_bit(1'b0, n);
        gap(1'b1, g);
        gap(1'b1, g);
        check("space period", 210 * MD, g);
        check("own carrier", 1, carrier_o);
        send_bit(1'b1, n);
        send_bit(1'b0, n);
        check("bit spacing", 1536, n + 1);
        tx_bit_valid_i = 1'b0;
        tx_enable_i = 1'b0;
        for (n = 0; n < 4000 && line_tx_oe_o !== 1'b0; n++) begin
            cyc(1);
        end
        cyc(2);
        check("released oe", 0, link.tx_carrier_oe);
        check("released line", 0, line_tx_o);
    endtask : t_tx

    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    initial begin
        #450_000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        cyc(3);
        rst_n_i = 1'b1;
        cyc(2);
        t_reset();
        t_rx();
        t_tx();
        tally_and_finish();
    end
endmodule : tb_fsk_modem_1200_bps
